// file: core/pscw_core.sv
// Port C strobe mux, clock output, wake control and external memory strobes.
// Assumes a classic Wishbone master, synchronous pin inputs and one clock.
//
// Design decisions made here: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps

// Summary of operation
// - Write-select clear leaves bit 6 as I/O, set drives the low write strobe.
// - Read-select clear leaves bit 7 as I/O, set drives the low read strobe.
// - Clock pin carries the reference clock at full rate or half in slow mode.
// - Writing zero to the clock-output enable stops driving the clock pin.
// - A falling wake edge during suspend restarts the oscillator and interrupts.
// - While wake is held low, suspend is refused.
// - A high test pin floats every functional pin.
// - A bus cycle takes four clocks.
// - The external address is 16 bits, not multiplexed with data.
// - Strobe length is adjustable by software.
module pscw_core
	import pscw_pkg::*;
#(
	parameter int STRETCH_W = 3
)
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   cyc_i,
	input  wire logic                   stb_i,
	input  wire logic                   we_i,
	input  wire logic [7:0]             adr_i,
	input  wire logic [3:0]             sel_i,
	input  wire logic [31:0]            dat_i,
	output logic      [31:0]            dat_o,
	output logic                        ack_o,
	output logic                        irq_o,
	input  wire logic [1:0]             pc_i,
	output logic      [1:0]             pc_o,
	output logic      [1:0]             pc_oe_n_o,
	output logic      [PSCW_ADDR_W-1:0] xaddr_o,
	output logic                        xaddr_oe_n_o,
	input  wire logic [PSCW_DATA_W-1:0] xdata_i,
	output logic      [PSCW_DATA_W-1:0] xdata_o,
	output logic                        xdata_oe_n_o,
	output logic                        clock_out_pin_o,
	output logic                        clock_out_oe_n_o,
	input  wire logic                   wake_n_i,
	input  wire logic                   test_float_i,
	input  wire logic                   cpu_speed_strap_i,
	output logic                        suspended_o,
	output logic                        osc_run_o,
	output logic                        bus_phase_end_o
);
	if (STRETCH_W < 3 || STRETCH_W > 4)
	begin
		$error("STRETCH_W must be 3 or 4");
	end

	logic [1:0]                 port_c_function_select_reg;
	logic                       clock_out_enable_reg;
	logic                       suspend_reg;
	logic                       speed_reg;
	logic [1:0]                 port_out_reg;
	logic [1:0]                 port_oe_reg;
	logic [PSCW_ADDR_W-1:0]     xaddr_reg;
	logic [PSCW_DATA_W-1:0]     xdata_reg;
	logic [PSCW_DATA_W-1:0]     xrdata_reg;
	logic                       xwrite_reg;
	logic [STRETCH_W-1:0]       stretch_reg;
	logic [STRETCH_W-1:0]       xcnt_reg;
	pscw_xstate_t               xstate_reg;
	logic [1:0]                 irq_stat_reg;
	logic [1:0]                 irq_mask_reg;
	logic [1:0]                 phase_reg;
	logic                       wake_d_reg;
	logic                       ack_reg;
	logic [31:0]                dat_reg;
	logic                       wr_stb;
	logic                       rd_stb;
	logic                       wake_fall;
	logic                       xdone;
	logic                       go;
	logic                       susp_req;
	logic                       clk_pin;
	logic                       clk_oe_n;
	logic [1:0]                 strobe_n;

	function automatic logic hit(input logic [7:0] ofs);
		hit = (adr_i == ofs);
	endfunction

	// ****************************************
	// Wishbone slave
	// ****************************************
	// One wait state: ack rises the cycle after the request, drops the next
	assign wr_stb = cyc_i && stb_i && we_i && !ack_reg && sel_i[0];
	assign rd_stb = cyc_i && stb_i && !we_i && !ack_reg;
	assign ack_o  = ack_reg;
	assign dat_o  = dat_reg;
	assign go     = wr_stb && hit(PSCW_OFS_XCTRL) && dat_i[PSCW_XC_GO_BIT]
		&& xstate_reg == PSCW_X_IDLE;
	assign susp_req = wr_stb && hit(PSCW_OFS_CPU_CS) && dat_i[PSCW_CS_SUSP_BIT];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= cyc_i && stb_i && !ack_reg;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_reg <= 32'h0;
		else if (rd_stb)
		begin
			unique case (adr_i)
				PSCW_OFS_PORT_FUNC: dat_reg <= {30'h0, port_c_function_select_reg};
				PSCW_OFS_CPU_CS:    dat_reg <= {29'h0, speed_reg, suspend_reg,
					clock_out_enable_reg};
				PSCW_OFS_PORT_OUT:  dat_reg <= {30'h0, port_out_reg};
				PSCW_OFS_PORT_OE:   dat_reg <= {30'h0, port_oe_reg};
				PSCW_OFS_PORT_IN:   dat_reg <= {30'h0, pc_i};
				PSCW_OFS_XADDR:     dat_reg <= {16'h0, xaddr_reg};
				PSCW_OFS_XDATA:     dat_reg <= {24'h0, xrdata_reg};
				PSCW_OFS_XCTRL:     dat_reg <= {23'h0, xstate_reg != PSCW_X_IDLE,
					1'b0, 3'(stretch_reg), 2'h0, xwrite_reg, 1'b0};
				PSCW_OFS_IRQ_STAT:  dat_reg <= {30'h0, irq_stat_reg};
				PSCW_OFS_IRQ_MASK:  dat_reg <= {30'h0, irq_mask_reg};
				default:            dat_reg <= 32'h0;
			endcase
		end
	end

	// ****************************************
	// Configuration registers
	// ****************************************
	// Selects clear at reset
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			port_c_function_select_reg <= PSCW_FUNC_RESET;
		else if (wr_stb && hit(PSCW_OFS_PORT_FUNC))
			port_c_function_select_reg <= dat_i[1:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			clock_out_enable_reg <= PSCW_CLKOE_RESET;
		else if (wr_stb && hit(PSCW_OFS_CPU_CS))
			clock_out_enable_reg <= dat_i[PSCW_CS_CLKOE_BIT];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			speed_reg <= 1'b0;
		else
			speed_reg <= cpu_speed_strap_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			port_out_reg <= 2'h0;
			port_oe_reg  <= 2'h0;
			xaddr_reg    <= 16'h0;
			xdata_reg    <= 8'h0;
			xwrite_reg   <= 1'b0;
			stretch_reg  <= STRETCH_W'(PSCW_STRETCH_RST);
			irq_mask_reg <= 2'h0;
		end
		else if (wr_stb)
		begin
			if (hit(PSCW_OFS_PORT_OUT))
				port_out_reg <= dat_i[1:0];
			if (hit(PSCW_OFS_PORT_OE))
				port_oe_reg <= dat_i[1:0];
			if (hit(PSCW_OFS_XADDR) && xstate_reg == PSCW_X_IDLE)
				xaddr_reg <= dat_i[PSCW_ADDR_W-1:0];
			if (hit(PSCW_OFS_XDATA) && xstate_reg == PSCW_X_IDLE)
				xdata_reg <= dat_i[PSCW_DATA_W-1:0];
			if (go)
			begin
				xwrite_reg  <= dat_i[PSCW_XC_WRITE_BIT];
				stretch_reg <= STRETCH_W'(dat_i[PSCW_XC_STRETCH_LSB +: 3]);
			end
			if (hit(PSCW_OFS_IRQ_MASK))
				irq_mask_reg <= dat_i[1:0];
		end
	end

	// ****************************************
	// Suspend and wake
	// ****************************************
	assign wake_fall = wake_d_reg && !wake_n_i;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wake_d_reg <= 1'b1;
		else
			wake_d_reg <= wake_n_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			suspend_reg <= 1'b0;
		else if (suspend_reg && wake_fall)
			suspend_reg <= 1'b0;
		else if (susp_req && wake_n_i)
			suspend_reg <= 1'b1;
	end

	assign suspended_o = suspend_reg;
	assign osc_run_o   = ~suspend_reg;

	// ****************************************
	// Interrupt status
	// ****************************************
	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			irq_stat_reg <= 2'h0;
		else
			irq_stat_reg <= (irq_stat_reg & ~((wr_stb && hit(PSCW_OFS_IRQ_STAT)) ?
				dat_i[1:0] : 2'h0)) | {xdone, suspend_reg && wake_fall};
	end

	assign irq_o = |(irq_stat_reg & irq_mask_reg);

	// ****************************************
	// Bus cycle phase
	// ****************************************
	// Four clocks per bus cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			phase_reg <= 2'h0;
		else
			phase_reg <= phase_reg + 2'h1;
	end

	assign bus_phase_end_o = (phase_reg == PSCW_BUS_CYC_CLKS);

	// ****************************************
	// External transfer engine
	// ****************************************
	// Strobe held for stretch plus one clocks
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			xstate_reg <= PSCW_X_IDLE;
			xcnt_reg   <= '0;
			xrdata_reg <= 8'h0;
		end
		else
		begin
			unique case (xstate_reg)
				PSCW_X_IDLE:
					if (go)
					begin
						xstate_reg <= PSCW_X_STROBE;
						xcnt_reg   <= STRETCH_W'(dat_i[PSCW_XC_STRETCH_LSB +: 3]);
					end
				PSCW_X_STROBE:
					if (xcnt_reg == '0)
					begin
						xstate_reg <= PSCW_X_HOLD;
						if (!xwrite_reg)
							xrdata_reg <= xdata_i;
					end
					else
						xcnt_reg <= xcnt_reg - 1'b1;
				PSCW_X_HOLD:
					xstate_reg <= PSCW_X_IDLE;
			endcase
		end
	end

	assign xdone = (xstate_reg == PSCW_X_HOLD);
	assign strobe_n[PSCW_PIN_WR] = !(xstate_reg == PSCW_X_STROBE && xwrite_reg);
	assign strobe_n[PSCW_PIN_RD] = !(xstate_reg == PSCW_X_STROBE && !xwrite_reg);

	// ****************************************
	// Pin multiplexing
	// ****************************************
	// Strobe or I/O, test floats all
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (port_c_function_select_reg[i])
			begin
				pc_o[i]      = strobe_n[i];
				pc_oe_n_o[i] = test_float_i;
			end
			else
			begin
				pc_o[i]      = port_out_reg[i];
				pc_oe_n_o[i] = test_float_i | ~port_oe_reg[i];
			end
		end
	end

	assign xaddr_o          = xaddr_reg;
	assign xaddr_oe_n_o     = test_float_i;
	assign xdata_o          = xdata_reg;
	assign xdata_oe_n_o     = test_float_i | !(xstate_reg == PSCW_X_STROBE && xwrite_reg);
	assign clock_out_pin_o  = clk_pin;
	assign clock_out_oe_n_o = clk_oe_n | test_float_i;

	pscw_clk_out u_clk_out (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.slow_i     (speed_reg),
		.enable_i   (clock_out_enable_reg && !suspend_reg),
		.clk_o      (clk_pin),
		.clk_oe_n_o (clk_oe_n)
	);

	// ****************************************
	// Checks
	// ****************************************
	AST_WR_MUX: assert property (@(posedge clk_i) disable iff (rst_i)
		port_c_function_select_reg[PSCW_PIN_WR] && !test_float_i |->
		!pc_oe_n_o[PSCW_PIN_WR] && pc_o[PSCW_PIN_WR] == strobe_n[PSCW_PIN_WR])
		else $error("write strobe not on pin");
	AST_RD_MUX: assert property (@(posedge clk_i) disable iff (rst_i)
		!port_c_function_select_reg[PSCW_PIN_RD] |->
		pc_o[PSCW_PIN_RD] == port_out_reg[PSCW_PIN_RD])
		else $error("read pin not general I/O");
	AST_CLK_OFF: assert property (@(posedge clk_i) disable iff (rst_i)
		!clock_out_enable_reg |-> clock_out_oe_n_o)
		else $error("clock pin driven while disabled");
	AST_WAKE: assert property (@(posedge clk_i) disable iff (rst_i)
		suspend_reg && wake_fall |=> !suspend_reg && irq_stat_reg[PSCW_IRQ_WAKE_BIT])
		else $error("wake edge did not resume");
	AST_NO_SUSP: assert property (@(posedge clk_i) disable iff (rst_i)
		!suspend_reg && !wake_n_i |=> !suspend_reg)
		else $error("suspended while wake low");
	AST_FLOAT: assert property (@(posedge clk_i) disable iff (rst_i)
		test_float_i |-> &pc_oe_n_o && xaddr_oe_n_o && xdata_oe_n_o && clock_out_oe_n_o)
		else $error("pin driven in test float");
	AST_PHASE: assert property (@(posedge clk_i) disable iff (rst_i)
		bus_phase_end_o |=> !bus_phase_end_o [*3] ##1 bus_phase_end_o)
		else $error("bus cycle not four clocks");
	AST_STRETCH: assert property (@(posedge clk_i) disable iff (rst_i)
		go && dat_i[PSCW_XC_STRETCH_LSB +: 3] == 3'h2 |=>
		(xstate_reg == PSCW_X_STROBE) [*3] ##1 xdone)
		else $error("strobe length wrong");
	AST_RESET_IO: assert property (@(posedge clk_i)
		$past(rst_i) && !rst_i |-> port_c_function_select_reg == 2'h0 && &pc_oe_n_o)
		else $error("pins not inputs after reset");
endmodule

// file: core/pscw_pkg.sv
// Package for the port strobe, clock and wake control block.
// Assumes a 32-bit classic Wishbone register bus and a single clock.
package pscw_pkg;

	// ****************************************
	// Register byte offsets
	// ****************************************
	localparam logic [7:0] PSCW_OFS_PORT_FUNC = 8'h00;
	localparam logic [7:0] PSCW_OFS_CPU_CS    = 8'h04;
	localparam logic [7:0] PSCW_OFS_PORT_OUT  = 8'h08;
	localparam logic [7:0] PSCW_OFS_PORT_OE   = 8'h0c;
	localparam logic [7:0] PSCW_OFS_PORT_IN   = 8'h10;
	localparam logic [7:0] PSCW_OFS_XADDR     = 8'h14;
	localparam logic [7:0] PSCW_OFS_XDATA     = 8'h18;
	localparam logic [7:0] PSCW_OFS_XCTRL     = 8'h1c;
	localparam logic [7:0] PSCW_OFS_IRQ_STAT  = 8'h20;
	localparam logic [7:0] PSCW_OFS_IRQ_MASK  = 8'h24;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int PSCW_FUNC_WR_BIT    = 0;
	localparam int PSCW_FUNC_RD_BIT    = 1;
	localparam int PSCW_CS_CLKOE_BIT   = 0;
	localparam int PSCW_CS_SUSP_BIT    = 1;
	localparam int PSCW_CS_SPEED_BIT   = 2;
	localparam int PSCW_PIN_WR         = 0;
	localparam int PSCW_PIN_RD         = 1;
	localparam int PSCW_XC_GO_BIT      = 0;
	localparam int PSCW_XC_WRITE_BIT   = 1;
	localparam int PSCW_XC_STRETCH_LSB = 4;
	localparam int PSCW_XC_BUSY_BIT    = 8;
	localparam int PSCW_IRQ_WAKE_BIT   = 0;
	localparam int PSCW_IRQ_XDONE_BIT  = 1;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [1:0] PSCW_FUNC_RESET   = 2'h0;
	localparam logic       PSCW_CLKOE_RESET  = 1'h1;
	localparam logic [2:0] PSCW_STRETCH_RST  = 3'h1;
	localparam logic [1:0] PSCW_BUS_CYC_CLKS = 2'h3;
	localparam int         PSCW_ADDR_W       = 16;
	localparam int         PSCW_DATA_W       = 8;

	typedef enum logic [1:0] {PSCW_X_IDLE, PSCW_X_STROBE, PSCW_X_HOLD} pscw_xstate_t;

endpackage

// file: core/pscw_clk_out.sv
// Clock output generator for the clock pin.
// Assumes clk_i is the fast phase-locked reference; toggling halves it.
`timescale 1ns/100ps
module pscw_clk_out
	import pscw_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic slow_i,
	input  wire logic enable_i,
	output logic      clk_o,
	output logic      clk_oe_n_o
);
	logic div_reg;

	// ****************************************
	// Divider
	// ****************************************
	// Full or half rate
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			div_reg <= 1'b0;
		else
			div_reg <= ~div_reg;
	end

	// Full rate passes the reference straight through; half rate uses the divider
	assign clk_o = slow_i ? div_reg : clk_i;
	assign clk_oe_n_o = ~enable_i;

	AST_CLKDIV: assert property (@(posedge clk_i) disable iff (rst_i)
		!$past(rst_i) |-> div_reg != $past(div_reg))
		else $error("clock divider did not toggle");
endmodule

// file: bench/pscw_xmem.sv
// External memory model on the port C strobe pins and the address/data lines.
// Assumes strobes are the low levels of bit 6 (write) and bit 7 (read).
`timescale 1ns/100ps
module pscw_xmem
(
	input  wire logic        clk_i,
	input  wire logic [1:0]  pin_i,
	input  wire logic [1:0]  pin_oe_n_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	output logic      [7:0]  rdata_o,
	output logic      [1:0]  level_o
);
	logic [7:0] mem [0:65535];
	logic [7:0] idle_reg = 8'h5a;

	// Board pull-ups hold undriven strobes inactive
	assign level_o[0] = pin_oe_n_i[0] ? 1'b1 : pin_i[0];
	assign level_o[1] = pin_oe_n_i[1] ? 1'b1 : pin_i[1];
	// Released bus wanders so a stale value never passes for read data
	assign rdata_o = level_o[1] ? idle_reg : mem[addr_i];

	always @(posedge clk_i)
	begin
		idle_reg <= ~idle_reg;
		if (level_o[0] === 1'b0)
			mem[addr_i] <= wdata_i;
	end
endmodule

// file: bench/tb_port_strobe_clock_wake_ctrl.sv
// Self-checking bench for the port strobe, clock and wake control block.
// Assumes the memory model on the strobe pins and a 50 ns clock.
`timescale 1ns/100ps
module tb_port_strobe_clock_wake_ctrl
	import pscw_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] dout;
	logic [31:0] rdat;
	logic [1:0]  pc_o;
	logic [1:0]  pc_oe_n;
	logic [1:0]  pc_lvl;
	logic [15:0] xaddr;
	logic [7:0]  xdi;
	logic [7:0]  xdo;
	logic        xaoe, xdoe, ck, ckoe, susp, osc, bpe, ack, irq;
	logic        wake_n = 1'b1;
	logic        tfl = 1'b0;
	logic        strap = 1'b0;
	logic [7:0]  last_rd = 8'h00;
	int          n_errors = 0;
	int          samples_checked = 0;
	int          cyc_cnt = 0;
	int          ck_cnt = 0;

	always #25 clk_i = ~clk_i;
	always @(posedge ck)
		ck_cnt++;

	pscw_core #(.STRETCH_W(3)) dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(dout), .ack_o(ack),
		.irq_o(irq), .pc_i(pc_lvl), .pc_o(pc_o), .pc_oe_n_o(pc_oe_n), .xaddr_o(xaddr),
		.xaddr_oe_n_o(xaoe), .xdata_i(xdi), .xdata_o(xdo), .xdata_oe_n_o(xdoe),
		.clock_out_pin_o(ck), .clock_out_oe_n_o(ckoe), .wake_n_i(wake_n),
		.test_float_i(tfl), .cpu_speed_strap_i(strap), .suspended_o(susp),
		.osc_run_o(osc), .bus_phase_end_o(bpe));

	pscw_xmem px (.clk_i(clk_i), .pin_i(pc_o), .pin_oe_n_i(pc_oe_n), .addr_i(xaddr),
		.wdata_i(xdo), .rdata_o(xdi), .level_o(pc_lvl));

	// ******************
	// Shared tasks
	// ******************
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
			@(posedge clk_i);
		while (ack !== 1'b1);
		rdat = dout;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string nm);
		wb(1'b0, a, 32'h0);
		chk(nm, e, rdat & m);
	endtask

	task automatic wrap_up;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ******************
	// Scenarios
	// ******************
	task automatic t_reset;
		rdc(PSCW_OFS_PORT_FUNC, 32'h3, 32'h0, "func"); // selects clear
		chk("pc_oe_n", 2'b11, pc_oe_n); // pins are inputs
		rdc(PSCW_OFS_CPU_CS, 32'h1, 32'h1, "clkoe"); // enable set
		rdc(8'hfc, 32'hffffffff, 32'h0, "unmapped");
		wb(1'b1, PSCW_OFS_PORT_OE, 32'h3);
		wb(1'b1, PSCW_OFS_PORT_OUT, 32'h1);
		chk("pc_o", 2'b01, pc_o); // plain I/O
		rdc(PSCW_OFS_PORT_IN, 32'h3, 32'h1, "pin_in"); // pins read back
		wb(1'b1, PSCW_OFS_PORT_OE, 32'h0);
		wb(1'b1, PSCW_OFS_PORT_FUNC, 32'h3);
		chk("strobe_idle", 4'h3, {pc_oe_n, pc_o}); // strobes idle high
	endtask

	task automatic t_xfer(input logic w, input logic [2:0] s, input logic [15:0] a,
		input logic [7:0] d);
		int lo;
		int b;
		lo = 0;
		b = w ? PSCW_PIN_WR : PSCW_PIN_RD;
		wb(1'b1, PSCW_OFS_XADDR, {16'h0, a});
		if (w)
			wb(1'b1, PSCW_OFS_XDATA, {24'h0, d});
		wb(1'b1, PSCW_OFS_XCTRL, {25'h0, s, 2'b0, w, 1'b1});
		repeat (24)
		begin
			if (pc_lvl[b] === 1'b0)
			begin
				lo++;
				chk("xaddr", {1'b0, a}, {xaoe, xaddr}); // full address
				if (w)
					chk("xdata", {1'b0, d}, {xdoe, xdo}); // data driven
			end
			@(posedge clk_i);
		end
		chk("strobe_len", s + 1, lo); // stretch
		rdc(PSCW_OFS_XCTRL, 32'h100, 32'h0, "busy");
		rdc(PSCW_OFS_XDATA, 32'hff, {24'h0, w ? last_rd : d}, "rdata"); // read back
		if (!w)
			last_rd = d;
		chk("irq_masked", 0, irq);
		wb(1'b1, PSCW_OFS_IRQ_MASK, 32'h2);
		chk("irq_xdone", 1, irq);
		wb(1'b1, PSCW_OFS_IRQ_STAT, 32'h2);
		chk("irq_clr", 0, irq);
		wb(1'b1, PSCW_OFS_IRQ_MASK, 32'h0);
	endtask

	task automatic t_clock(input logic s, input int e);
		@(posedge clk_i);
		strap <= s;
		rdc(PSCW_OFS_CPU_CS, 32'h4, {29'h0, s, 2'h0}, "strap"); // strap seen
		@(negedge clk_i);
		ck_cnt = 0;
		repeat (20) @(negedge clk_i);
		chk("clk_edges", e, ck_cnt); // pin rate
		chk("ckoe", 0, ckoe); // pin driven
	endtask

	task automatic t_wake;
		wb(1'b1, PSCW_OFS_CPU_CS, 32'h0);
		chk("ckoe_off", 1, ckoe); // pin released
		wb(1'b1, PSCW_OFS_IRQ_MASK, 32'h1);
		wake_n <= 1'b0;
		wb(1'b1, PSCW_OFS_CPU_CS, 32'h3);
		repeat (2) @(posedge clk_i);
		chk("susp_held", 0, susp); // refused
		wake_n <= 1'b1;
		wb(1'b1, PSCW_OFS_CPU_CS, 32'h3);
		repeat (2) @(posedge clk_i);
		chk("susp", 4'b1001, {susp, osc, irq, ckoe});
		wake_n <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk("wake", 4'b0110, {susp, osc, irq, ckoe}); // resume and interrupt
		wb(1'b1, PSCW_OFS_IRQ_STAT, 32'h1);
		chk("irq_wclr", 0, irq);
		wake_n <= 1'b1;
		wb(1'b1, PSCW_OFS_IRQ_MASK, 32'h0);
	endtask

	task automatic t_misc;
		int n;
		n = 0;
		tfl <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk("float", 5'h1f, {pc_oe_n, xaoe, xdoe, ckoe}); // all pins float
		tfl <= 1'b0;
		while (bpe !== 1'b1 && ++n < 10)
			@(posedge clk_i);
		n = 0;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (bpe !== 1'b1 && n < 10);
		chk("bus_cycle", 4, n); // four clocks
		// Reset again in mid-run with both strobes selected
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(PSCW_OFS_PORT_FUNC, 32'h3, 32'h0, "func_rerst"); // selects clear again
		chk("pc_rerst", 3'b011, {irq, pc_oe_n}); // pins are inputs
	endtask

	// Hang guard well above the few hundred cycles the run needs
	always @(posedge clk_i)
	begin
		cyc_cnt++;
		if (cyc_cnt == 5000)
		begin
			n_errors++;
			wrap_up();
		end
	end

	initial
	begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_xfer(1'b1, 3'h0, 16'hbeef, 8'h3c);
		t_xfer(1'b0, 3'h0, 16'hbeef, 8'h3c);
		t_xfer(1'b1, 3'h7, 16'h0001, 8'ha5);
		t_xfer(1'b0, 3'h7, 16'h0001, 8'ha5);
		t_xfer(1'b1, 3'h2, 16'h8000, 8'h96);
		t_xfer(1'b0, 3'h2, 16'h8000, 8'h96);
		t_clock(1'b1, 10);
		t_clock(1'b0, 20);
		t_wake();
		t_misc();
		wrap_up();
	end
endmodule
